/* hw/rwin_cfg.svh */
// Purpose: Constants for the calendar clock register-window block
// Assumes: 16-bit configuration registers, byte-wide time fields
// Notes: Offsets here are window select codes, not bus addresses
`ifndef RWIN_CFG_SVH
`define RWIN_CFG_SVH

// ----------------------------------------------------------------------
// Field positions in the two configuration registers
// ----------------------------------------------------------------------
`define RWIN_PTR_LSB 8
`define RWIN_PTR_MSB 9
`define RWIN_WREN_BIT 13

// ----------------------------------------------------------------------
// Pointer codes and reset values
// ----------------------------------------------------------------------
`define RWIN_PTR_MIN_SEC 2'h0
`define RWIN_PTR_WD_HR 2'h1
`define RWIN_PTR_MON_DAY 2'h2
`define RWIN_PTR_YEAR 2'h3
`define RWIN_CFG_RST 16'h0000
`define RWIN_FIELD_RST 8'h00

`endif

/* hw/rwin_pkg.sv */
// Purpose: Types shared by the register-window block
// Assumes: Included constants header rwin_cfg.svh
// Notes: Structs carry grouped bus and field signals
package rwin_pkg;

	// One window access from the peripheral bus
	typedef struct packed {
		logic wr_hi;
		logic wr_lo;
		logic rd_hi;
		logic rd_lo;
		logic [7:0] wdata;
	} rwin_acc_t;

	// A set of byte fields selected by a pointer
	typedef struct packed {
		logic [7:0] f3_lo;
		logic [7:0] f2_hi;
		logic [7:0] f2_lo;
		logic [7:0] f1_hi;
		logic [7:0] f1_lo;
		logic [7:0] f0_hi;
		logic [7:0] f0_lo;
	} rwin_fields_t;

endpackage

/* hw/rwin_window.sv */
// Purpose: One pointer-driven 16-bit value window with its byte fields
// Assumes: Accesses arrive as one-cycle strobes synchronous to i_mclk
// Notes: Pointer 11 has only an optional low field (year for time)
`timescale 1ns/100ps
`include "rwin_cfg.svh"
module rwin_window
	import rwin_pkg::*;
#(
	parameter bit HAS_F3 = 1'b1
)
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Access and pointer control
	input wire rwin_acc_t i_acc,
	input wire logic i_wr_en,
	input wire logic i_ptr_load,
	input wire logic [1:0] i_ptr_wdata,
	// State out
	output logic [1:0] o_ptr,
	output logic [15:0] o_rdata,
	output rwin_fields_t o_fields
);

	typedef struct packed {
		logic [1:0] ptr;
		rwin_fields_t f;
	} rwin_win_st_t;

	rwin_win_st_t s_q;
	rwin_win_st_t s_d;

	// Pointer step down, saturating at the bottom pair
	function automatic logic [1:0] dec_sat(input logic [1:0] p);
		dec_sat = (p == `RWIN_PTR_MIN_SEC) ? p : p - 2'h1;
	endfunction

	// ----------------------------------------------------------------
	// Next state: store, then step the pointer
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (i_wr_en && i_acc.wr_hi)
		begin
			case (s_q.ptr)
				`RWIN_PTR_MIN_SEC: s_d.f.f0_hi = i_acc.wdata;
				`RWIN_PTR_WD_HR: s_d.f.f1_hi = i_acc.wdata;
				`RWIN_PTR_MON_DAY: s_d.f.f2_hi = i_acc.wdata;
				default: ;
			endcase
		end
		if (i_wr_en && i_acc.wr_lo)
		begin
			case (s_q.ptr)
				`RWIN_PTR_MIN_SEC: s_d.f.f0_lo = i_acc.wdata;
				`RWIN_PTR_WD_HR: s_d.f.f1_lo = i_acc.wdata;
				`RWIN_PTR_MON_DAY: s_d.f.f2_lo = i_acc.wdata;
				default: if (HAS_F3) s_d.f.f3_lo = i_acc.wdata;
			endcase
		end
		// Pointer moves on high write or any read; software load wins
		if (i_ptr_load)
			s_d.ptr = i_ptr_wdata;
		else if (i_acc.wr_hi || i_acc.rd_hi || i_acc.rd_lo)
			s_d.ptr = dec_sat(s_q.ptr);
		if (!HAS_F3)
			s_d.f.f3_lo = `RWIN_FIELD_RST;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Read mux of the current pair
	always_comb
	begin
		case (s_q.ptr)
			`RWIN_PTR_MIN_SEC: o_rdata = {s_q.f.f0_hi, s_q.f.f0_lo};
			`RWIN_PTR_WD_HR: o_rdata = {s_q.f.f1_hi, s_q.f.f1_lo};
			`RWIN_PTR_MON_DAY: o_rdata = {s_q.f.f2_hi, s_q.f.f2_lo};
			default: o_rdata = {`RWIN_FIELD_RST, s_q.f.f3_lo};
		endcase
	end

	assign o_ptr = s_q.ptr;
	assign o_fields = s_q.f;

endmodule

/* hw/rwin_top.sv */
// Purpose: Calendar clock time and alarm register windows with pointers
// Assumes: Peripheral bus gives one-cycle byte strobes, synchronous inputs
// Notes: Reads return data registered one cycle after the read strobe
`timescale 1ns/100ps
`include "rwin_cfg.svh"
module rwin_top
	import rwin_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Clock configuration register write
	input wire logic i_ccfg_wr,
	input wire logic [15:0] i_ccfg_wdata,
	// Alarm configuration register write
	input wire logic i_acfg_wr,
	input wire logic [15:0] i_acfg_wdata,
	// Window accesses
	input wire rwin_acc_t i_time_acc,
	input wire rwin_acc_t i_alarm_acc,
	// Read back
	output logic [15:0] o_clock_config_calibration_reg,
	output logic [15:0] o_alarm_config_reg,
	output logic [15:0] o_time_rdata,
	output logic [15:0] o_alarm_rdata,
	// Field contents for the timekeeping and alarm logic
	output rwin_fields_t o_time_fields,
	output rwin_fields_t o_alarm_fields
);

	typedef struct packed {
		logic [15:0] ccfg;
		logic [15:0] acfg;
		logic [15:0] trd;
		logic [15:0] ard;
		rwin_fields_t tf;
		rwin_fields_t af;
	} rwin_top_st_t;

	rwin_top_st_t s_q;
	rwin_top_st_t s_d;
	logic [1:0] time_window_pointer;
	logic [1:0] alarm_window_pointer;
	logic [15:0] time_mux;
	logic [15:0] alarm_mux;
	rwin_fields_t time_f;
	rwin_fields_t alarm_f;
	logic timekeeping_write_enable;

	// Write enable guards the time fields only
	assign timekeeping_write_enable = s_q.ccfg[`RWIN_WREN_BIT];

	// ----------------------------------------------------------------
	// Time window, pointer in clock configuration bits 9:8
	// ----------------------------------------------------------------
	rwin_window #(.HAS_F3(1'b1)) u_time
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_acc(i_time_acc),
		.i_wr_en(timekeeping_write_enable),
		.i_ptr_load(i_ccfg_wr),
		.i_ptr_wdata(i_ccfg_wdata[`RWIN_PTR_MSB:`RWIN_PTR_LSB]),
		.o_ptr(time_window_pointer),
		.o_rdata(time_mux),
		.o_fields(time_f)
	);

	// ----------------------------------------------------------------
	// Alarm window, pointer in alarm configuration bits 9:8
	// ----------------------------------------------------------------
	rwin_window #(.HAS_F3(1'b0)) u_alarm
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_acc(i_alarm_acc),
		.i_wr_en(1'b1),
		.i_ptr_load(i_acfg_wr),
		.i_ptr_wdata(i_acfg_wdata[`RWIN_PTR_MSB:`RWIN_PTR_LSB]),
		.o_ptr(alarm_window_pointer),
		.o_rdata(alarm_mux),
		.o_fields(alarm_f)
	);

	// ----------------------------------------------------------------
	// Config registers keep pointer bits at zero; outputs registered
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (i_ccfg_wr)
			s_d.ccfg = i_ccfg_wdata;
		if (i_acfg_wr)
			s_d.acfg = i_acfg_wdata;
		// Pointer bits live in the windows; a copy here would lag a step
		s_d.ccfg[`RWIN_PTR_MSB:`RWIN_PTR_LSB] = 2'h0;
		s_d.acfg[`RWIN_PTR_MSB:`RWIN_PTR_LSB] = 2'h0;
		// Capture pair shown when the read is made, before it steps
		if (i_time_acc.rd_hi || i_time_acc.rd_lo)
			s_d.trd = time_mux;
		if (i_alarm_acc.rd_hi || i_alarm_acc.rd_lo)
			s_d.ard = alarm_mux;
		s_d.tf = time_f;
		s_d.af = alarm_f;
	end

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Pointer field comes straight from the window's own flip-flops
	assign o_clock_config_calibration_reg = {s_q.ccfg[15:`RWIN_PTR_MSB + 1],
		time_window_pointer, s_q.ccfg[`RWIN_PTR_LSB - 1:0]};
	assign o_alarm_config_reg = {s_q.acfg[15:`RWIN_PTR_MSB + 1],
		alarm_window_pointer, s_q.acfg[`RWIN_PTR_LSB - 1:0]};
	assign o_time_rdata = s_q.trd;
	assign o_alarm_rdata = s_q.ard;
	assign o_time_fields = s_q.tf;
	assign o_alarm_fields = s_q.af;

endmodule

/* verification/rwin_assertions.sv */
// Purpose: Pointer window checks on the top ports
// Assumes: One clock, active-low async reset
// Notes: Fields show two cycles after a store
`timescale 1ns/100ps
module rwin_assertions
	import rwin_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Watched ports
	input wire logic i_ccfg_wr,
	input wire logic [15:0] i_ccfg_wdata,
	input wire logic i_acfg_wr,
	input wire logic [15:0] i_acfg_wdata,
	input wire rwin_acc_t i_time_acc,
	input wire rwin_acc_t i_alarm_acc,
	input wire logic [15:0] o_clock_config_calibration_reg,
	input wire logic [15:0] o_alarm_config_reg,
	input wire rwin_fields_t o_time_fields
);
	// ----
	// Helpers
	// ----
	logic [1:0] tp;
	logic [1:0] ap;
	logic td;
	logic ad;
	// Steps are hi writes and any read; lo writes never step
	assign tp = o_clock_config_calibration_reg[9:8];
	assign ap = o_alarm_config_reg[9:8];
	assign td = i_time_acc.wr_hi | i_time_acc.rd_hi | i_time_acc.rd_lo;
	assign ad = i_alarm_acc.wr_hi | i_alarm_acc.rd_hi | i_alarm_acc.rd_lo;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	AST_TPTR_LOAD: assert property (
		i_ccfg_wr |=> tp == $past(i_ccfg_wdata[9:8]))
		else $error("time pointer load wrong");
	AST_TPTR_DEC: assert property (
		td && !i_ccfg_wr && tp != 2'h0 |=> tp == $past(tp) - 2'h1)
		else $error("time pointer step wrong");
	AST_TPTR_FLOOR: assert property (
		td && !i_ccfg_wr && tp == 2'h0 |=> tp == 2'h0)
		else $error("time pointer left floor");
	AST_TPTR_HOLD: assert property (
		!td && !i_ccfg_wr |=> $stable(tp))
		else $error("time pointer moved");
	AST_APTR_LOAD: assert property (
		i_acfg_wr |=> ap == $past(i_acfg_wdata[9:8]))
		else $error("alarm pointer load wrong");
	AST_APTR_DEC: assert property (
		ad && !i_acfg_wr && ap != 2'h0 |=> ap == $past(ap) - 2'h1)
		else $error("alarm pointer step wrong");
	AST_APTR_FLOOR: assert property (
		ad && !i_acfg_wr && ap == 2'h0 |=> ap == 2'h0)
		else $error("alarm pointer left floor");
	AST_WREN_BLOCK: assert property (
		i_time_acc.wr_lo && !i_time_acc.wr_hi &&
		!o_clock_config_calibration_reg[13] |=> ##1 $stable(o_time_fields))
		else $error("locked time write stored");
	// Main scenarios
	COV_TDEC: cover property (td && tp == 2'h3);
	COV_AFLOOR: cover property (ad && ap == 2'h0);
	COV_LOCK: cover property (i_time_acc.wr_lo && !o_clock_config_calibration_reg[13]);
endmodule

/* verification/rwin_top_tb.sv */
// Purpose: Self-checking bench for the register windows
// Assumes: Strobes driven at the falling edge, one cycle wide
// Notes: Model keeps each window as pointer-indexed byte pairs
`timescale 1ns/100ps
module rwin_top_tb
	import rwin_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_ccfg_wr = 1'b0;
	logic i_acfg_wr = 1'b0;
	logic [15:0] i_ccfg_wdata = 16'h0000;
	logic [15:0] i_acfg_wdata = 16'h0000;
	rwin_acc_t i_time_acc = '0;
	rwin_acc_t i_alarm_acc = '0;
	logic [15:0] o_ccfg, o_acfg, o_trd, o_ard;
	rwin_fields_t o_tf, o_af;
	int fail_count = 0;
	int samples_checked = 0;
	logic [1:0] ptr [2] = '{default: 2'h0};
	logic [7:0] mem [2][4][2] = '{default: 8'h00};
	logic wren = 1'b0;
	// ----
	// Clock and device
	// ----
	always #50 i_mclk = ~i_mclk;
	rwin_top dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ccfg_wr(i_ccfg_wr),
		.i_ccfg_wdata(i_ccfg_wdata), .i_acfg_wr(i_acfg_wr),
		.i_acfg_wdata(i_acfg_wdata), .i_time_acc(i_time_acc),
		.i_alarm_acc(i_alarm_acc), .o_clock_config_calibration_reg(o_ccfg),
		.o_alarm_config_reg(o_acfg), .o_time_rdata(o_trd),
		.o_alarm_rdata(o_ard), .o_time_fields(o_tf), .o_alarm_fields(o_af));
	// Compare and count
	task chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Config write; data goes to both, only one strobe rises
	task cfg(input int w, input logic [15:0] d);
		@(negedge i_mclk);
		i_ccfg_wr = (w == 0);
		i_acfg_wr = (w == 1);
		i_ccfg_wdata = d;
		i_acfg_wdata = d;
		@(posedge i_mclk);
		ptr[w] = d[9:8];
		if (w == 0) wren = d[13];
		@(negedge i_mclk);
		i_ccfg_wr = 1'b0;
		i_acfg_wr = 1'b0;
		chk(64'(w ? o_acfg : o_ccfg), 64'(d));
	endtask
	// Window access k: 0 hi write, 1 lo write, 2 hi read, 3 lo read
	task acc(input int w, input int k, input logic [7:0] d);
		rwin_acc_t a;
		logic [15:0] e;
		int p;
		a = '0;
		a[11-k] = 1'b1;
		a.wdata = d;
		p = ptr[w];
		e = {mem[w][p][1], mem[w][p][0]};
		@(negedge i_mclk);
		if (w == 0) i_time_acc = a;
		else i_alarm_acc = a;
		@(posedge i_mclk);
		if (k == 0 && p != 3 && (w == 1 || wren)) mem[w][p][1] = d;
		if (k == 1 && !(w == 1 && p == 3) && (w == 1 || wren))
			mem[w][p][0] = d;
		if (k != 1 && p != 0) ptr[w] = 2'(p - 1);
		@(negedge i_mclk);
		i_time_acc = '0;
		i_alarm_acc = '0;
		chk(64'(w ? o_acfg[9:8] : o_ccfg[9:8]),
			64'(ptr[w]));
		if (k > 1) chk(64'(w ? o_ard : o_trd), 64'(e));
	endtask
	// Single closing point
	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Walk each window down from 3 twice, by writes then by reads; time window unlocked then locked, alarm window never locked
	initial
	begin
		int w, e;
		void'($urandom(32'h186b8e92));
		repeat (10) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rstn = 1'b1;
		for (w = 0; w < 2; w++)
			for (e = 1; e >= 0; e--)
			begin
				cfg(w, {2'h0, e[0], 13'h0300});
				repeat (4)
				begin
					acc(w, 1, 8'($urandom));
					acc(w, 0, 8'($urandom));
				end
				cfg(w, {2'h0, e[0], 13'h0300});
				repeat (5) acc(w, 2 + $urandom % 2, 8'h00);
				chk(64'(w ? o_af : o_tf),
					64'({mem[w][3][0], mem[w][2][1], mem[w][2][0],
					mem[w][1][1], mem[w][1][0], mem[w][0][1],
					mem[w][0][0]}));
			end
		end_of_test();
	end
endmodule
bind rwin_top rwin_assertions chk_u (.i_mclk(i_mclk), .i_rstn(i_rstn),
	.i_ccfg_wr(i_ccfg_wr), .i_ccfg_wdata(i_ccfg_wdata), .i_acfg_wr(i_acfg_wr),
	.i_acfg_wdata(i_acfg_wdata), .i_time_acc(i_time_acc),
	.i_alarm_acc(i_alarm_acc), .o_time_fields(o_time_fields),
	.o_clock_config_calibration_reg(o_clock_config_calibration_reg),
	.o_alarm_config_reg(o_alarm_config_reg));
